// [hw/mcm_pkg.sv]
package mcm_pkg;
	// width of the configuration word seen at the cfg ports
	localparam int CFG_W = 16;
	// field positions inside the configuration word
	localparam int P3_INC_A_BIT = 6;
	localparam int P3_INC_B_BIT = 7;
	localparam int P3_INC_C_BIT = 8;
	localparam int ANGLE_LO_BIT = 9;
	localparam int ANGLE_HI_BIT = 10;
	localparam int NOMINAL_VOLTAGE_VALUE_A_BIT = 11;
	localparam int NOMINAL_VOLTAGE_VALUE_B_BIT = 12;
	localparam int NOMINAL_VOLTAGE_VALUE_C_BIT = 13;
	localparam int FREQ_BIT = 14;
	// values after reset
	localparam logic [2:0] P3_INC_RST = 3'h7;
	localparam logic [1:0] ANGLE_RST = 2'h0;
	localparam logic [2:0] NOMINAL_VOLTAGE_VALUE_EN_RST = 3'h0;
	localparam logic FREQ_RST = 1'b0;
	// bits of the word held here; the rest read as zero
	localparam logic [CFG_W-1:0] CFG_MASK = 16'h7fc0;
	// angle selector codes
	localparam logic [1:0] ANG_V_TO_I = 2'h0;
	localparam logic [1:0] ANG_V_TO_V = 2'h1;
	localparam logic [1:0] ANG_I_TO_I = 2'h2;
	localparam logic [1:0] ANG_NONE = 2'h3;
	// datapath widths
	localparam int VW = 24;
	localparam int PW = 32;
	localparam int SUMW = 34;

	// decoded configuration fields, index 0 is phase a
	typedef struct packed {
		logic line_freq_range_select;
		logic [2:0] nominal_volt_en;
		logic [1:0] angle_measure_select;
		logic [2:0] pulse3_phase_include;
	} mcm_cfg_t;

	// per-phase samples from the measurement front end
	typedef struct packed {
		logic [VW-1:0] vrms;
		logic [VW-1:0] irms;
		logic signed [VW-1:0] vinst;
		logic signed [VW-1:0] iinst;
		logic signed [PW-1:0] power;
	} mcm_phase_in_t;

	// per-phase results after nominal voltage substitution
	typedef struct packed {
		logic [VW-1:0] vrms_eff;
		logic signed [VW-1:0] vinst_eff;
		logic [2*VW-1:0] apparent;
	} mcm_phase_out_t;

	// operands handed to the angle measurement logic
	typedef struct packed {
		logic signed [VW-1:0] x;
		logic signed [VW-1:0] y;
	} mcm_angle_t;
endpackage

// [hw/mcm_phase_path.sv]
`timescale 1ns/1ps
// one phase of the rms / apparent power path with nominal voltage override
module mcm_phase_path
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic nominal_voltage_value_en,
	input wire logic [mcm_pkg::VW-1:0] nominal_voltage_value,
	input wire mcm_pkg::mcm_phase_in_t phase_in,
	output mcm_pkg::mcm_phase_out_t phase_out
);
	// voltage used for every rms instance of this phase
	logic [mcm_pkg::VW-1:0] vrms_sel;
	// full-width product, no truncation
	logic [2*mcm_pkg::VW-1:0] prod;
	mcm_pkg::mcm_phase_out_t out_reg;

	// substitution is a plain mux so both paths have the same latency
	always_comb
	begin
		vrms_sel = nominal_voltage_value_en ? nominal_voltage_value : phase_in.vrms;
		prod = (2*mcm_pkg::VW)'(vrms_sel) * (2*mcm_pkg::VW)'(phase_in.irms);
	end

	// results registered every clock
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_reg <= '0;
		end
		else
		begin
			out_reg.vrms_eff <= vrms_sel;
			// applied voltage input ignored while overridden
			out_reg.vinst_eff <= nominal_voltage_value_en ? '0 : phase_in.vinst;
			out_reg.apparent <= prod;
		end
	end

	assign phase_out = out_reg;

	// override replaces rms and mutes the applied voltage
	nominal_voltage_value_override_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		nominal_voltage_value_en |=> (phase_out.vrms_eff == $past(nominal_voltage_value))
			&& (phase_out.vinst_eff == '0))
		else $error("nominal voltage override not applied");

	// regular path uses the measured rms in the apparent power
	nominal_voltage_value_regular_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!nominal_voltage_value_en |=> phase_out.apparent
			== (2*mcm_pkg::VW)'($past(phase_in.vrms)) * (2*mcm_pkg::VW)'($past(phase_in.irms)))
		else $error("regular apparent power wrong");
endmodule

// [hw/mcm_config_core.sv]
`timescale 1ns/1ps
module mcm_config_core
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic cfg_wr,
	input wire logic [mcm_pkg::CFG_W-1:0] cfg_wdata,
	input wire logic comp_cycle,
	input wire logic [mcm_pkg::VW-1:0] nominal_voltage_value,
	input wire mcm_pkg::mcm_phase_in_t [2:0] phase_in,
	output logic [mcm_pkg::CFG_W-1:0] cfg_rdata,
	output logic line_freq_range_select,
	output logic angle_meas_en,
	output mcm_pkg::mcm_angle_t [2:0] angle_pair,
	output logic signed [mcm_pkg::SUMW-1:0] third_pulse_output,
	output mcm_pkg::mcm_phase_out_t [2:0] phase_out
);
	// fields as written by software
	mcm_pkg::mcm_cfg_t shadow_reg;
	// fields the datapath uses, loaded at computation cycle start
	mcm_pkg::mcm_cfg_t active_reg;
	// decoded write data
	mcm_pkg::mcm_cfg_t wr_fields;
	// voltage samples with overridden phases muted
	logic signed [mcm_pkg::VW-1:0] v_use [3];
	logic signed [mcm_pkg::SUMW-1:0] p3_next;
	mcm_pkg::mcm_angle_t [2:0] angle_next;
	logic angle_en_next;
	logic signed [mcm_pkg::SUMW-1:0] third_reg;
	mcm_pkg::mcm_angle_t [2:0] angle_reg;
	logic angle_en_reg;
	logic [mcm_pkg::CFG_W-1:0] rdata_reg;
	logic freq_reg;

	// field extraction from the written word
	always_comb
	begin
		wr_fields.pulse3_phase_include = {cfg_wdata[mcm_pkg::P3_INC_C_BIT],
			cfg_wdata[mcm_pkg::P3_INC_B_BIT], cfg_wdata[mcm_pkg::P3_INC_A_BIT]};
		wr_fields.angle_measure_select =
			cfg_wdata[mcm_pkg::ANGLE_HI_BIT:mcm_pkg::ANGLE_LO_BIT];
		wr_fields.nominal_volt_en = {cfg_wdata[mcm_pkg::NOMINAL_VOLTAGE_VALUE_C_BIT],
			cfg_wdata[mcm_pkg::NOMINAL_VOLTAGE_VALUE_B_BIT], cfg_wdata[mcm_pkg::NOMINAL_VOLTAGE_VALUE_A_BIT]};
		wr_fields.line_freq_range_select = cfg_wdata[mcm_pkg::FREQ_BIT];
	end

	// software copy, also the readback source
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shadow_reg <= '{line_freq_range_select: mcm_pkg::FREQ_RST,
				nominal_volt_en: mcm_pkg::NOMINAL_VOLTAGE_VALUE_EN_RST,
				angle_measure_select: mcm_pkg::ANGLE_RST,
				pulse3_phase_include: mcm_pkg::P3_INC_RST};
		end
		else if (cfg_wr)
		begin
			shadow_reg <= wr_fields;
		end
	end

	// a change mid-cycle would mix two settings in one result,
	// so the datapath only picks it up on the cycle boundary
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active_reg <= '{line_freq_range_select: mcm_pkg::FREQ_RST,
				nominal_volt_en: mcm_pkg::NOMINAL_VOLTAGE_VALUE_EN_RST,
				angle_measure_select: mcm_pkg::ANGLE_RST,
				pulse3_phase_include: mcm_pkg::P3_INC_RST};
		end
		else if (comp_cycle)
		begin
			// a write in the same cycle goes straight through
			active_reg <= cfg_wr ? wr_fields : shadow_reg;
		end
	end

	// readback places the fields back at their bit positions
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_reg <= '0;
			freq_reg <= mcm_pkg::FREQ_RST;
		end
		else
		begin
			rdata_reg <= '0;
			rdata_reg[mcm_pkg::P3_INC_C_BIT:mcm_pkg::P3_INC_A_BIT] <=
				shadow_reg.pulse3_phase_include;
			rdata_reg[mcm_pkg::ANGLE_HI_BIT:mcm_pkg::ANGLE_LO_BIT] <=
				shadow_reg.angle_measure_select;
			rdata_reg[mcm_pkg::NOMINAL_VOLTAGE_VALUE_C_BIT:mcm_pkg::NOMINAL_VOLTAGE_VALUE_A_BIT] <= shadow_reg.nominal_volt_en;
			rdata_reg[mcm_pkg::FREQ_BIT] <= shadow_reg.line_freq_range_select;
			// range choice is passed to the filters, not checked here
			freq_reg <= active_reg.line_freq_range_select;
		end
	end

	// per-phase rms / apparent power paths
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_phase
			// bit 11 + gi of the word enables the override
			mcm_phase_path u_path
			(
				.core_clk(core_clk),
				.rst_n(rst_n),
				.nominal_voltage_value_en(active_reg.nominal_volt_en[gi]),
				.nominal_voltage_value(nominal_voltage_value),
				.phase_in(phase_in[gi]),
				.phase_out(phase_out[gi])
			);
			// overridden phases feed nothing from their voltage pin
			assign v_use[gi] = active_reg.nominal_volt_en[gi] ? '0 : phase_in[gi].vinst;
		end
	endgenerate

	// third pulse output: sum of included phase powers
	always_comb
	begin
		p3_next = '0;
		for (int i = 0; i < 3; i++)
		begin
			if (active_reg.pulse3_phase_include[i])
			begin
				p3_next = p3_next + mcm_pkg::SUMW'(phase_in[i].power);
			end
		end
	end

	// angle operand routing by selector code
	always_comb
	begin
		angle_next = '0;
		angle_en_next = 1'b1;
		case (active_reg.angle_measure_select)
			mcm_pkg::ANG_V_TO_I:
			begin
				// each voltage against its own current
				for (int i = 0; i < 3; i++)
				begin
					angle_next[i].x = v_use[i];
					angle_next[i].y = phase_in[i].iinst;
				end
			end
			mcm_pkg::ANG_V_TO_V:
			begin
				// a-b, b-c, c-a
				for (int i = 0; i < 3; i++)
				begin
					angle_next[i].x = v_use[i];
					angle_next[i].y = v_use[(i + 1) % 3];
				end
			end
			mcm_pkg::ANG_I_TO_I:
			begin
				for (int i = 0; i < 3; i++)
				begin
					angle_next[i].x = phase_in[i].iinst;
					angle_next[i].y = phase_in[(i + 1) % 3].iinst;
				end
			end
			default:
			begin
				// code 11: measurement idle, operands held at zero
				angle_en_next = 1'b0;
			end
		endcase
	end

	// output registers
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			third_reg <= '0;
			angle_reg <= '0;
			angle_en_reg <= 1'b0;
		end
		else
		begin
			third_reg <= p3_next;
			angle_reg <= angle_next;
			angle_en_reg <= angle_en_next;
		end
	end

	assign cfg_rdata = rdata_reg;
	assign line_freq_range_select = freq_reg;
	assign third_pulse_output = third_reg;
	assign angle_pair = angle_reg;
	assign angle_meas_en = angle_en_reg;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_write;
		cfg_wr && !comp_cycle;
	endsequence
	sequence s_apply;
		comp_cycle && !cfg_wr;
	endsequence

	pulse3_c_only_a: assert property (
		active_reg.pulse3_phase_include == 3'h4
			|=> third_pulse_output == mcm_pkg::SUMW'($past(phase_in[2].power)))
		else $error("phase c alone not summed");

	pulse3_b_only_a: assert property (
		active_reg.pulse3_phase_include == 3'h2
			|=> third_pulse_output == mcm_pkg::SUMW'($past(phase_in[1].power)))
		else $error("phase b alone not summed");

	pulse3_sum_all_a: assert property (
		active_reg.pulse3_phase_include == 3'h7
			|=> third_pulse_output == mcm_pkg::SUMW'($past(phase_in[0].power))
				+ mcm_pkg::SUMW'($past(phase_in[1].power))
				+ mcm_pkg::SUMW'($past(phase_in[2].power)))
		else $error("three-phase sum wrong");

	angle_vi_a: assert property (
		active_reg.angle_measure_select == mcm_pkg::ANG_V_TO_I
			|=> angle_meas_en && angle_pair[1].y == $past(phase_in[1].iinst))
		else $error("voltage-current angle routing wrong");

	angle_vv_a: assert property (
		active_reg.angle_measure_select == mcm_pkg::ANG_V_TO_V
			|=> angle_meas_en && angle_pair[2].y == $past(v_use[0]))
		else $error("voltage-voltage angle routing wrong");

	angle_ii_a: assert property (
		active_reg.angle_measure_select == mcm_pkg::ANG_I_TO_I
			|=> angle_meas_en && angle_pair[0].x == $past(phase_in[0].iinst)
				&& angle_pair[0].y == $past(phase_in[1].iinst))
		else $error("current-current angle routing wrong");

	angle_off_a: assert property (
		active_reg.angle_measure_select == mcm_pkg::ANG_NONE
			|=> !angle_meas_en && angle_pair == '0)
		else $error("angle measurement not idle");

	cfg_apply_a: assert property (
		s_write ##1 s_apply
			|=> ({7'h0, active_reg} << mcm_pkg::P3_INC_A_BIT)
				== ($past(cfg_wdata, 2) & mcm_pkg::CFG_MASK))
		else $error("write not applied at next computation cycle");

	cfg_readback_a: assert property (
		cfg_wr ##1 !cfg_wr |=> cfg_rdata == ($past(cfg_wdata, 2) & mcm_pkg::CFG_MASK))
		else $error("readback differs from written value");

	nominal_voltage_value_mute_a: assert property (
		active_reg.nominal_volt_en[0] && active_reg.angle_measure_select == mcm_pkg::ANG_V_TO_I
			|=> angle_pair[0].x == '0)
		else $error("overridden voltage reached angle logic");
endmodule

// [testbench/metering_compute_mode_config_tb.sv]
`timescale 1ns/1ps
// self-checking bench: drives the config core and compares with a model
module metering_compute_mode_config_tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0; // asserted from time zero
	logic cfg_wr = 1'b0;
	logic [15:0] cfg_wdata = 16'h0;
	logic comp_cycle = 1'b0;
	logic [23:0] nominal_voltage_value = 24'h0;
	mcm_pkg::mcm_phase_in_t [2:0] phase_in = '0;
	logic [15:0] cfg_rdata;
	logic line_freq_range_select;
	logic angle_meas_en;
	mcm_pkg::mcm_angle_t [2:0] angle_pair;
	logic signed [33:0] third_pulse_output;
	mcm_pkg::mcm_phase_out_t [2:0] phase_out;
	// model: word as read back, and word the datapath runs on
	logic [15:0] m_word;
	logic [15:0] m_act;
	int failures = 0;
	int checks = 0;

	// 50 MHz core clock
	always #10 core_clk = ~core_clk;

	mcm_config_core i_mcm_config_core (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata),
		.comp_cycle(comp_cycle),
		.nominal_voltage_value(nominal_voltage_value),
		.phase_in(phase_in),
		.cfg_rdata(cfg_rdata),
		.line_freq_range_select(line_freq_range_select),
		.angle_meas_en(angle_meas_en),
		.angle_pair(angle_pair),
		.third_pulse_output(third_pulse_output),
		.phase_out(phase_out)
	);

	// readback word comparison
	task cmp_word(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// datapath result comparison, values zero or sign extended to 96 bits
	task cmp_data(input string name, input logic [95:0] exp, input logic [95:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// single place where the run ends
	task print_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// reset for 16 cycles; model falls back to the documented defaults
	task do_reset;
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (15) @(posedge core_clk);
		#1;
		cmp_word("rdata_in_reset", 16'h0, cfg_rdata);
		cmp_data("third_in_reset", 96'h0, 96'(third_pulse_output));
		@(posedge core_clk);
		rst_n <= 1'b1;
		m_word = 16'h01c0;
		m_act = 16'h01c0;
	endtask

	// one write strobe; bits outside 6..14 are not kept
	task wr(input logic [15:0] w);
		@(posedge core_clk);
		cfg_wr <= 1'b1;
		cfg_wdata <= w;
		@(posedge core_clk);
		cfg_wr <= 1'b0;
		m_word = w & 16'h7fc0;
	endtask

	// computation cycle start moves the written word into use
	task apply;
		@(posedge core_clk);
		comp_cycle <= 1'b1;
		@(posedge core_clk);
		comp_cycle <= 1'b0;
		m_act = m_word;
	endtask

	// fresh random samples on every phase and the nominal voltage
	task rnd_in;
		@(posedge core_clk);
		nominal_voltage_value <= 24'($urandom);
		for (int i = 0; i < 3; i++)
			phase_in[i] <= {$urandom, $urandom, $urandom, $urandom};
	endtask

	// let the datapath settle on stable inputs, then compare everything
	task check_all;
		logic signed [33:0] sum;
		logic [23:0] vv [3];
		logic [23:0] ii [3];
		mcm_pkg::mcm_phase_out_t po;
		mcm_pkg::mcm_angle_t pr;
		repeat (3) @(posedge core_clk);
		#1;
		sum = '0;
		cmp_word("cfg_rdata", m_word, cfg_rdata);
		cmp_data("freq_sel", 96'(m_act[14]), 96'(line_freq_range_select));
		cmp_data("angle_en", 96'(m_act[10:9] != 2'h3), 96'(angle_meas_en));
		for (int i = 0; i < 3; i++)
		begin
			// an overridden phase ignores its voltage input entirely
			vv[i] = m_act[11+i] ? 24'h0 : phase_in[i].vinst;
			ii[i] = phase_in[i].iinst;
			po.vrms_eff = m_act[11+i] ? nominal_voltage_value : phase_in[i].vrms;
			po.vinst_eff = vv[i];
			po.apparent = 48'(po.vrms_eff) * 48'(phase_in[i].irms);
			cmp_data("phase_out", 96'(po), 96'(phase_out[i]));
			if (m_act[6+i])
				sum = sum + 34'(phase_in[i].power);
		end
		for (int i = 0; i < 3; i++)
		begin
			// pairs run a-b, b-c, c-a for the phase to phase modes
			case (m_act[10:9])
				2'h0: pr = {vv[i], ii[i]};
				2'h1: pr = {vv[i], vv[(i+1)%3]};
				2'h2: pr = {ii[i], ii[(i+1)%3]};
				default: pr = '0;
			endcase
			cmp_data("angle_pair", 96'(pr), 96'(angle_pair[i]));
		end
		cmp_data("third", 96'(sum), 96'(third_pulse_output));
	endtask

	// main sequence
	initial
	begin
		logic [15:0] w;
		void'($urandom(32'he42b925f));
		do_reset;
		rnd_in;
		check_all;
		// every include mask against every angle code, random elsewhere
		for (int k = 0; k < 32; k++)
		begin
			w = 16'($urandom);
			w[8:6] = k[2:0];
			w[10:9] = k[4:3];
			rnd_in;
			wr(w);
			check_all;
			apply;
			check_all;
		end
		// back to back writes, the second on the computation cycle edge
		@(posedge core_clk);
		cfg_wr <= 1'b1;
		cfg_wdata <= 16'h1234;
		@(posedge core_clk);
		cfg_wdata <= 16'hffff;
		comp_cycle <= 1'b1;
		@(posedge core_clk);
		cfg_wr <= 1'b0;
		comp_cycle <= 1'b0;
		m_word = 16'h7fc0;
		m_act = m_word;
		check_all;
		// write, then a computation cycle on the very next edge
		@(posedge core_clk);
		cfg_wr <= 1'b1;
		cfg_wdata <= 16'h2a40;
		@(posedge core_clk);
		cfg_wr <= 1'b0;
		comp_cycle <= 1'b1;
		@(posedge core_clk);
		comp_cycle <= 1'b0;
		m_word = 16'h2a40 & 16'h7fc0;
		m_act = m_word;
		check_all;
		// reset in mid-run must bring back the defaults
		do_reset;
		check_all;
		print_verdict;
	end
endmodule
